// ===== adcsr_defines.vh
// Constants for the serial converter readout block
`ifndef ADCSR_DEFINES_VH
`define ADCSR_DEFINES_VH

// Clock period of MCLK_IN in picoseconds
`define ADCSR_CLK_PERIOD_PS   8000
// Shift clocks in one output frame
`define ADCSR_FRAME_CLKS      16
// Leading zero bits ahead of the result in a frame
`define ADCSR_LEAD_ZEROS      2
// Default result width, the wider variant
`define ADCSR_RES_BITS        14
// Convert pulses with a static shift clock that select each low-power mode
`define ADCSR_NAP_PULSES      2
`define ADCSR_SLEEP_PULSES    4
// Least time from the last frame clock to the next convert start
`define ADCSR_T7_NS           45
`define ADCSR_T7_CYC          ((`ADCSR_T7_NS * 1000 + `ADCSR_CLK_PERIOD_PS - 1) / `ADCSR_CLK_PERIOD_PS)
// Shortest full sample period the block keeps up with
`define ADCSR_THRU_NS         286
`define ADCSR_THRU_CYC        ((`ADCSR_THRU_NS * 1000) / `ADCSR_CLK_PERIOD_PS)

`endif

// ===== adcsr_buf2.v
// Two-entry result buffer with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none

module adcsr_buf2 #(
  parameter WIDTH = 14
) (
  // Clock, reset and enable
  input  wire             clk_in,
  input  wire             srst_in,
  input  wire             ce_in,
  // Filling side
  input  wire             in_valid_in,
  output wire             in_ready_out,
  input  wire [WIDTH-1:0] in_data_in,
  // Draining side
  output wire             out_valid_out,
  input  wire             out_ready_in,
  output wire [WIDTH-1:0] out_data_out
);

  reg [WIDTH-1:0] mem_q [0:1];
  reg             wr_q;
  reg             rd_q;
  reg [1:0]       cnt_q;

  wire push = in_valid_in && (cnt_q != 2'd2);
  wire pop  = out_ready_in && (cnt_q != 2'd0);

  // Full and empty come straight from the occupancy count
  assign in_ready_out  = (cnt_q != 2'd2);
  assign out_valid_out = (cnt_q != 2'd0);
  assign out_data_out  = mem_q[rd_q];

  // Pointers and storage
  always @(posedge clk_in) begin
    if (srst_in) begin
      wr_q  <= 1'b0;
      rd_q  <= 1'b0;
      cnt_q <= 2'd0;
    end else if (ce_in) begin
      if (push) begin
        mem_q[wr_q] <= in_data_in;
        wr_q        <= ~wr_q;
      end
      if (pop)
        rd_q <= ~rd_q;
      if (push && !pop)
        cnt_q <= cnt_q + 2'd1;
      else if (pop && !push)
        cnt_q <= cnt_q - 2'd1;
    end
  end

endmodule // adcsr_buf2

`default_nettype wire

// ===== adcsr_top.v
// Serial readout and conversion sequencing of a sampling converter
`timescale 1ns/1ps
`default_nettype none
`include "adcsr_defines.vh"

// Overview of operation
// (R1) After each convert_start rise the result leaves on serial_out within 16 shift clocks.
// (R2) The controller runs the shift clock fast enough and leaves two spare clocks for acquisition.
// (R3) A whole sample period of conversion plus acquisition may be as short as 286 ns.
// (R4) Result words are 12 bits wide in the narrow variant and 14 in the wide one.
// (R5) The controller leaves at least 45 ns from the 16th shift rise to the next convert rise.
// (R6) Result bits leave one after another, each one moved by a shift clock edge.
// (R7) The input difference is coded as unipolar straight binary with no sign bit.
// (R8) The link is three wires: convert_start and shift clock in, serial_out back.
// (R9) Every rising shift clock edge advances conversion and moves out the next bit; here only rises inside a frame count, and the 16th ends it.
// (R10) Each word shifted out belongs to the sample taken at the previous conversion.
// (R11) Two convert pulses with a static shift clock enter light shutdown.
// (R12) Four or more such pulses enter deep sleep, and a shift clock pulse wakes the part.
// (R13) The controller captures each bit on the rising shift edge and assembles the word.
module adcsr_top #(
  parameter RES_BITS = `ADCSR_RES_BITS
) (
  // Clock, reset and enable
  input  wire                MCLK_IN,
  input  wire                SRST_IN,
  input  wire                CE_IN,
  // Three-wire link pins
  input  wire                CONVERT_START_IN,
  input  wire                SHIFT_CLOCK_IN,
  output wire                SERIAL_OUT_OUT,
  output wire                SERIAL_OUT_OE_OUT,
  // Sampled value from the analog front end
  input  wire [RES_BITS-1:0] SAMPLE_IN,
  // Status
  output wire                BUSY_OUT,
  output wire                LIGHT_SHUTDOWN_OUT,
  output wire                DEEP_SLEEP_OUT,
  output wire                ACQ_SHORT_OUT,
  output wire                RESULT_STALL_OUT
);

  localparam ST_IDLE  = 1'b0;
  localparam ST_FRAME = 1'b1;
  localparam FRAME    = `ADCSR_FRAME_CLKS;
  localparam PAD      = FRAME - `ADCSR_LEAD_ZEROS - RES_BITS;
  // Integer forms first, then cut on purpose to the widths of the counters they meet
  localparam T7_CYC_I       = `ADCSR_T7_CYC;
  localparam NAP_N_I        = `ADCSR_NAP_PULSES;
  localparam SLEEP_N_I      = `ADCSR_SLEEP_PULSES;
  localparam [3:0] T7_CYC   = T7_CYC_I[3:0];
  localparam [2:0] NAP_N    = NAP_N_I[2:0];
  localparam [2:0] SLEEP_N  = SLEEP_N_I[2:0];

  // Pin synchronisers: three stages, filtered level moves when stages two and three agree
  reg  [1:0] s1_q;
  reg  [1:0] s2_q;
  reg  [1:0] s3_q;
  reg  [1:0] lvl_q;
  reg  [1:0] lvl_d1_q;
  wire [1:0] pin_raw = {SHIFT_CLOCK_IN, CONVERT_START_IN};

  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : g_sync
      always @(posedge MCLK_IN) begin
        if (SRST_IN) begin
          s1_q[g]     <= 1'b0;
          s2_q[g]     <= 1'b0;
          s3_q[g]     <= 1'b0;
          lvl_q[g]    <= 1'b0;
          lvl_d1_q[g] <= 1'b0;
        end else if (CE_IN) begin
          s1_q[g]     <= pin_raw[g];
          s2_q[g]     <= s1_q[g];
          s3_q[g]     <= s2_q[g];
          if (s2_q[g] == s3_q[g])
            lvl_q[g] <= s3_q[g];
          lvl_d1_q[g] <= lvl_q[g];
        end
      end
    end
  endgenerate

  wire convert_start_rise = lvl_q[0] & ~lvl_d1_q[0];
  wire sck_rise  = lvl_q[1] & ~lvl_d1_q[1];

  // Frame state
  reg                state_q;
  reg  [4:0]         bit_cnt_q;
  reg  [FRAME-1:0]   shift_q;
  reg                sdo_q;
  reg                sdo_oe_q;
  reg  [RES_BITS-1:0] held_q;
  reg  [RES_BITS-1:0] pend_data_q;
  reg                pend_q;
  reg  [3:0]         acq_cnt_q;
  reg                acq_short_q;
  reg  [2:0]         pulse_cnt_q;
  reg                nap_q;
  reg                sleep_q;
  reg                stall_q;

  // Buffer between finished conversions and the output shifter
  wire                buf_in_ready;
  wire                buf_out_valid;
  wire [RES_BITS-1:0] buf_out_data;

  // (R10) one-deep latency
  adcsr_buf2 #(
    .WIDTH (RES_BITS)
  ) u_buf (
    .clk_in        (MCLK_IN),
    .srst_in       (SRST_IN),
    .ce_in         (CE_IN),
    .in_valid_in   (pend_q),
    .in_ready_out  (buf_in_ready),
    .in_data_in    (pend_data_q),
    .out_valid_out (buf_out_valid),
    .out_ready_in  (convert_start_rise & ~sleep_q),
    .out_data_out  (buf_out_data)
  );

  // (R4) word width by variant
  // (R7) straight binary, no sign extension
  wire [FRAME-1:0] word_ext = {{(FRAME-RES_BITS){1'b0}}, buf_out_data};
  wire [FRAME-1:0] frame_w  = buf_out_valid ? (word_ext << PAD) : {FRAME{1'b0}};

  // Conversion and shift sequencer
  always @(posedge MCLK_IN) begin
    if (SRST_IN) begin
      state_q     <= ST_IDLE;
      bit_cnt_q   <= 5'd0;
      shift_q     <= {FRAME{1'b0}};
      sdo_q       <= 1'b0;
      sdo_oe_q    <= 1'b0;
      held_q      <= {RES_BITS{1'b0}};
      pend_data_q <= {RES_BITS{1'b0}};
      pend_q      <= 1'b0;
      stall_q     <= 1'b0;
    end else if (CE_IN) begin
      // Hand the finished word to the buffer; held until it has room
      if (pend_q && buf_in_ready)
        pend_q <= 1'b0;
      stall_q <= pend_q & ~buf_in_ready;
      // (R3) a new conversion is taken at any time outside deep sleep, no dead time after a frame
      if (convert_start_rise && !sleep_q) begin
        // (R1) frame opens on convert rise
        held_q    <= SAMPLE_IN;
        state_q   <= ST_FRAME;
        bit_cnt_q <= 5'd0;
        shift_q   <= frame_w << 1;
        sdo_q     <= frame_w[FRAME-1];
        sdo_oe_q  <= 1'b1;
      end else begin
        case (state_q)
          ST_IDLE: begin
            sdo_oe_q <= 1'b0;
          end
          ST_FRAME: begin
            // (R9) advance on each shift rise
            if (sck_rise) begin
              bit_cnt_q <= bit_cnt_q + 5'd1;
              // (R6) next bit out
              sdo_q   <= shift_q[FRAME-1];
              shift_q <= shift_q << 1;
              if (bit_cnt_q == FRAME - 1) begin
                // (R1) frame ends, output released after 16 clocks
                state_q     <= ST_IDLE;
                sdo_oe_q    <= 1'b0;
                sdo_q       <= 1'b0;
                // (R10) result waits for the next frame
                pend_data_q <= held_q;
                pend_q      <= 1'b1;
              end
            end
          end
          default: begin
            state_q <= ST_IDLE;
          end
        endcase
      end
    end
  end

  // Acquisition window check; the controller owns this spacing, we only report it
  always @(posedge MCLK_IN) begin
    if (SRST_IN) begin
      acq_cnt_q   <= T7_CYC;
      acq_short_q <= 1'b0;
    end else if (CE_IN) begin
      acq_short_q <= 1'b0;
      if (state_q == ST_FRAME && sck_rise && bit_cnt_q == FRAME - 1)
        acq_cnt_q <= 4'd0;
      else if (acq_cnt_q != T7_CYC)
        acq_cnt_q <= acq_cnt_q + 4'd1;
      // (R5) flag a convert rise inside the acquisition time
      if (convert_start_rise && acq_cnt_q != T7_CYC)
        acq_short_q <= 1'b1;
    end
  end

  // Low-power mode detect: convert pulses counted while the shift clock stays still
  always @(posedge MCLK_IN) begin
    if (SRST_IN) begin
      pulse_cnt_q <= 3'd0;
      nap_q       <= 1'b0;
      sleep_q     <= 1'b0;
    end else if (CE_IN) begin
      if (sck_rise) begin
        // (R12) any shift pulse wakes
        pulse_cnt_q <= 3'd0;
        nap_q       <= 1'b0;
        sleep_q     <= 1'b0;
      end else if (convert_start_rise) begin
        if (pulse_cnt_q != SLEEP_N)
          pulse_cnt_q <= pulse_cnt_q + 3'd1;
        // (R11) second pulse naps
        if (pulse_cnt_q + 3'd1 == NAP_N)
          nap_q <= 1'b1;
        // (R12) fourth pulse sleeps
        if (pulse_cnt_q + 3'd1 >= SLEEP_N) begin
          nap_q   <= 1'b0;
          sleep_q <= 1'b1;
        end
      end
    end
  end

  // (R8) single data wire back, driven only during a frame
  assign SERIAL_OUT_OUT     = sdo_q;
  assign SERIAL_OUT_OE_OUT  = sdo_oe_q;
  assign BUSY_OUT           = state_q;
  assign LIGHT_SHUTDOWN_OUT = nap_q;
  assign DEEP_SLEEP_OUT     = sleep_q;
  assign ACQ_SHORT_OUT      = acq_short_q;
  assign RESULT_STALL_OUT   = stall_q;

endmodule // adcsr_top

`default_nettype wire

// ===== adcsr_checker.sv
// Pin-level checker for the converter readout block
`timescale 1ns/1ps
`default_nettype none
module adcsr_checker (
  input wire logic MCLK_IN,
  input wire logic SRST_IN,
  input wire logic CONVERT_START_IN,
  input wire logic SHIFT_CLOCK_IN,
  input wire logic SERIAL_OUT_OUT,
  input wire logic SERIAL_OUT_OE_OUT,
  input wire logic BUSY_OUT,
  input wire logic LIGHT_SHUTDOWN_OUT,
  input wire logic DEEP_SLEEP_OUT,
  input wire logic ACQ_SHORT_OUT
);
  logic       cv_q = 1'b0;
  logic       sh_q = 1'b0;
  logic [4:0] cv_age_q = 5'h1f;
  logic [4:0] sh_age_q = 5'h1f;
  // Cycles since each pin rose; saturates so stale edges never look fresh
  always @(posedge MCLK_IN) begin
    cv_q     <= CONVERT_START_IN;
    sh_q     <= SHIFT_CLOCK_IN;
    cv_age_q <= (CONVERT_START_IN && !cv_q) ? 5'h00 : cv_age_q + {4'h0, cv_age_q != 5'h1f};
    sh_age_q <= (SHIFT_CLOCK_IN && !sh_q) ? 5'h00 : sh_age_q + {4'h0, sh_age_q != 5'h1f};
  end
  default clocking cb @(posedge MCLK_IN); endclocking
  default disable iff (SRST_IN);
  property p_rst_quiet;
    disable iff (1'b0) SRST_IN |=> !SERIAL_OUT_OE_OUT && !BUSY_OUT && !DEEP_SLEEP_OUT;
  endproperty
  a_rst_quiet: assert property (p_rst_quiet)
    else $error("outputs not cleared by reset");
  property p_busy_oe;
    BUSY_OUT == SERIAL_OUT_OE_OUT;
  endproperty
  a_busy_oe: assert property (p_busy_oe)
    else $error("busy and output enable disagree");
  property p_lead;
    $rose(SERIAL_OUT_OE_OUT) |-> !SERIAL_OUT_OUT && cv_age_q >= 5'h02 && cv_age_q <= 5'h08;
  endproperty
  a_lead: assert property (p_lead)
    else $error("frame start not led by zero after convert");
  property p_shift;
    SERIAL_OUT_OE_OUT && $past(SERIAL_OUT_OE_OUT) && $changed(SERIAL_OUT_OUT)
      |-> sh_age_q <= 5'h08 || cv_age_q <= 5'h08;
  endproperty
  a_shift: assert property (p_shift)
    else $error("data moved without a shift edge");
  property p_oe_fall;
    $fell(SERIAL_OUT_OE_OUT) |-> sh_age_q <= 5'h08;
  endproperty
  a_oe_fall: assert property (p_oe_fall)
    else $error("output released without a shift edge");
  property p_acq;
    ACQ_SHORT_OUT |-> cv_age_q <= 5'h08 ##1 !ACQ_SHORT_OUT;
  endproperty
  a_acq: assert property (p_acq)
    else $error("short acquisition flag misplaced");
  property p_wake;
    $fell(DEEP_SLEEP_OUT) |-> sh_age_q <= 5'h08;
  endproperty
  a_wake: assert property (p_wake)
    else $error("sleep left without a shift pulse");
  property p_nap;
    $rose(LIGHT_SHUTDOWN_OUT) |-> sh_age_q > 5'h10 && cv_age_q <= 5'h08 && !DEEP_SLEEP_OUT;
  endproperty
  a_nap: assert property (p_nap)
    else $error("nap entered while shift clock active");
  property p_refuse;
    DEEP_SLEEP_OUT |-> !$rose(SERIAL_OUT_OE_OUT);
  endproperty
  a_refuse: assert property (p_refuse)
    else $error("conversion started in sleep");
endmodule // adcsr_checker
`default_nettype wire

// ===== adcsr_ctrl_model.sv
// Controller model: drives convert and shift pins, collects result words
`timescale 1ns/1ps
`default_nettype none
module adcsr_ctrl_model (
  input  wire logic clk_in,
  input  wire logic sdo_in,
  input  wire logic sdo_oe_in,
  output var  logic convert_start_out,
  output var  logic sck_out
);
  logic last_q = 1'b0;
  logic line;
  // A released line shows the inverse of its last value, never a stale copy
  assign line = sdo_oe_in ? sdo_in : ~last_q;
  always @(posedge clk_in) if (sdo_oe_in) last_q <= sdo_in;
  initial begin
    convert_start_out = 1'b0;
    sck_out  = 1'b0;
  end
  task wait_n(input int n);
    repeat (n) @(negedge clk_in);
  endtask
  // single convert pulse, each level held four cycles
  task pulse_convert_start();
    convert_start_out = 1'b1;
    wait_n(4);
    convert_start_out = 1'b0;
    wait_n(4);
  endtask
  // Frames leave the shift clock high, so drop it first to make a real rising edge
  task pulse_sck();
    sck_out = 1'b0;
    wait_n(4);
    sck_out = 1'b1;
    wait_n(4);
    sck_out = 1'b0;
    wait_n(4);
  endtask
  // one frame; bits taken at each rise, gap of hp plus extra after 16th
  task frame(input int hp, input int extra, output logic [15:0] word);
    convert_start_out = 1'b1;
    wait_n(4);
    sck_out  = 1'b0;
    convert_start_out = 1'b0;
    wait_n(4);
    for (int i = 0; i < 16; i++) begin
      word    = {word[14:0], line};
      sck_out = 1'b1;
      wait_n(hp);
      if (i < 15) begin
        sck_out = 1'b0;
        wait_n(hp);
      end
    end
    wait_n(extra);
  endtask
endmodule // adcsr_ctrl_model
`default_nettype wire

// ===== adcsr_top_tb.sv
// Self-checking bench for the converter readout block
`timescale 1ns/1ps
`default_nettype none
module adcsr_top_tb;
  logic        clk, srst, ce, convert_start, sck, serial_out, oe, lite, deep, acq, stall;
  logic        acq_seen = 1'b0;
  logic [13:0] sample;
  logic [15:0] w;
  int          n_mismatch;
  int          n_checks;
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  adcsr_top #(.RES_BITS(14)) dut (
    .MCLK_IN(clk), .SRST_IN(srst), .CE_IN(ce),
    .CONVERT_START_IN(convert_start), .SHIFT_CLOCK_IN(sck),
    .SERIAL_OUT_OUT(serial_out), .SERIAL_OUT_OE_OUT(oe), .SAMPLE_IN(sample),
    .BUSY_OUT(), .LIGHT_SHUTDOWN_OUT(lite), .DEEP_SLEEP_OUT(deep),
    .ACQ_SHORT_OUT(acq), .RESULT_STALL_OUT(stall)
  );
  adcsr_ctrl_model ctrl (
    .clk_in(clk), .sdo_in(serial_out), .sdo_oe_in(oe), .convert_start_out(convert_start), .sck_out(sck)
  );
  // Sticky copy of the one-cycle short acquisition pulse
  always @(negedge clk) if (acq === 1'b1) acq_seen <= 1'b1;
  task chk_word(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task chk_flag(input logic got, input logic exp);
    chk_word({15'h0000, got}, {15'h0000, exp});
  endtask
  task summarize();
    if (n_mismatch == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // Back-to-back frames at two shift rates; full scale, zero and the 2a55 pattern are read back
  task t_stream();
    logic [13:0] vals [4] = '{14'h3fff, 14'h0000, 14'h2a55, 14'h0001};
    logic [13:0] prev;
    prev = 14'h0000;
    for (int i = 0; i < 4; i++) begin
      sample = vals[i];
      ctrl.frame((i % 2) ? 7 : 4, 4, w);
      chk_word(w, {2'b00, prev});
      prev = vals[i];
    end
    chk_flag(oe, 1'b0);
    chk_flag(acq_seen, 1'b0);
    chk_flag(stall, 1'b0);
  endtask
  // Clock enable low: convert pulses must leave no trace
  task t_freeze();
    ce = 1'b0;
    ctrl.pulse_convert_start();
    ctrl.pulse_convert_start();
    ce = 1'b1;
    ctrl.wait_n(8);
    chk_flag(lite, 1'b0);
    chk_flag(oe, 1'b0);
  endtask
  // Next convert only four cycles after the 16th shift rise
  task t_acq();
    ctrl.frame(4, 0, w);
    ctrl.frame(4, 8, w);
    chk_flag(acq_seen, 1'b1);
  endtask
  // Convert pulses with a static shift clock, then a wake pulse
  task t_power();
    ctrl.pulse_convert_start();
    ctrl.pulse_convert_start();
    chk_flag(lite, 1'b1);
    ctrl.pulse_convert_start();
    ctrl.pulse_convert_start();
    chk_flag(deep, 1'b1);
    chk_flag(lite, 1'b0);
    ctrl.pulse_convert_start();
    chk_flag(deep, 1'b1);
    ctrl.pulse_sck();
    chk_flag(deep, 1'b0);
    chk_flag(lite, 1'b0);
  endtask
  initial begin
    srst       = 1'b1;
    sample     = 14'h0000;
    ce         = 1'b1;
    n_mismatch = 0;
    n_checks   = 0;
    repeat (3) @(negedge clk);
    srst = 1'b0;
    t_stream();
    t_freeze();
    t_acq();
    t_power();
    summarize();
  end
  // Whole run is about 1100 cycles; this bound is far beyond it
  initial begin
    #200000;
    n_mismatch++;
    summarize();
  end
endmodule // adcsr_top_tb
bind adcsr_top adcsr_checker u_chk (
  .MCLK_IN(MCLK_IN), .SRST_IN(SRST_IN), .CONVERT_START_IN(CONVERT_START_IN),
  .SHIFT_CLOCK_IN(SHIFT_CLOCK_IN), .SERIAL_OUT_OUT(SERIAL_OUT_OUT),
  .SERIAL_OUT_OE_OUT(SERIAL_OUT_OE_OUT), .BUSY_OUT(BUSY_OUT),
  .LIGHT_SHUTDOWN_OUT(LIGHT_SHUTDOWN_OUT), .DEEP_SLEEP_OUT(DEEP_SLEEP_OUT),
  .ACQ_SHORT_OUT(ACQ_SHORT_OUT)
);
`default_nettype wire
